// ---- common/dstc_consts.svh ----
// Constants of the DMA socket transfer control block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package and the design files.
`ifndef DSTC_CONSTS_SVH
`define DSTC_CONSTS_SVH

// Register offsets (byte addresses within one socket window)
`define DSTC_OFF_COUNT     8'h00
`define DSTC_OFF_LENGTH    8'h04
`define DSTC_OFF_STATUS    8'h0C
`define DSTC_OFF_FLAGS     8'h10
`define DSTC_OFF_MASK      8'h14

// Control and status field positions
`define DSTC_B_GO_ENABLE   31
`define DSTC_B_GO_PAUSE    30
`define DSTC_B_UNIT        29
`define DSTC_B_WRAPUP      28
`define DSTC_B_P_EOP       27
`define DSTC_B_P_LENGTH    26
`define DSTC_B_P_LAST      25
`define DSTC_B_P_PARTIAL   24
`define DSTC_B_EN_CONS     23
`define DSTC_B_EN_PROD     22
`define DSTC_B_TRUNCATE    21
`define DSTC_B_ZLP         18

// Writable control bits and their reset value
`define DSTC_CTRL_RW_MASK  32'hEFE0_07FF
`define DSTC_CTRL_RST      32'h04E0_0000

// Interrupt flag layout
`define DSTC_FLG_W         10
`define DSTC_FLG_DONE      0
`define DSTC_FLG_ZLP       1
`define DSTC_FLG_P_REQ     5
`define DSTC_FLG_P_EOP     6
`define DSTC_FLG_P_LENGTH  7
`define DSTC_FLG_P_LAST    8
`define DSTC_FLG_P_PART    9
`define DSTC_FLG_RST       10'h000
`define DSTC_MASK_RST      10'h000

// State codes shown in the status register
`define DSTC_SC_OFF        3'h0
`define DSTC_SC_FETCH      3'h1
`define DSTC_SC_WAIT       3'h2
`define DSTC_SC_ACT        3'h3
`define DSTC_SC_PAUSE      3'h4

// Cycles by which the enabled status trails the run request
`define DSTC_EN_LAG        4

`endif

// ---- common/dstc_pkg.sv ----
// Types of the DMA socket transfer control block.
// Assumes the constants header sits on the include path.
`include "dstc_consts.svh"

package dstc_pkg;

   // Socket operating states
   typedef enum logic [2:0] {
      ST_OFF,
      ST_FETCH,
      ST_WAIT,
      ST_ACT,
      ST_PAUSE
   } dstc_state_t;

endpackage

// ---- verilog/dstc_lag.sv ----
// Delay line that makes the enabled status trail the run request.
// Assumes its input comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module dstc_lag #(
   parameter int N = 4
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic resetn,
   // Request in, lagged status out
   input  wire logic go,
   output logic      lagged
);

   logic [N-1:0] sh_q;

   // Shift the request through N stages
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sh_q <= '0;
      end else begin
         sh_q <= {sh_q[N-2:0], go};
      end
   end

   assign lagged = sh_q[N-1];

endmodule

`default_nettype wire

// ---- verilog/dstc_top.sv ----
// Transfer length, progress and run/pause control of one DMA socket.
// Assumes a classic Wishbone master and a descriptor engine on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "dstc_consts.svh"

module dstc_top (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // Wishbone slave
   input  wire logic        wb_cyc,
   input  wire logic        wb_stb,
   input  wire logic        wb_we,
   input  wire logic [7:0]  wb_adr,
   input  wire logic [3:0]  wb_sel,
   input  wire logic [31:0] wb_dat_w,
   output logic      [31:0] wb_dat_r,
   output logic             wb_ack,
   // Interrupt
   output logic             irq,
   // Descriptor engine
   output logic             dsc_fetch_req,
   input  wire logic        dsc_fetch_done,
   input  wire logic        dsc_ready,
   input  wire logic [15:0] dsc_size,
   input  wire logic [15:0] dsc_bytes,
   input  wire logic        dsc_event,
   // Buffer completion
   input  wire logic        buf_done,
   input  wire logic [15:0] buf_bytes,
   input  wire logic        buf_eop,
   // Core control
   output logic             xfer_run,
   output logic             xfer_abort,
   output logic             xfer_wrapup,
   output logic             dsc_writeback_en,
   output logic             tail_forward,
   output logic             prod_events_en,
   output logic             cons_events_en
);
   import dstc_pkg::*;

   // Registers
   dstc_state_t             state_q;
   dstc_state_t             state_d;
   logic [31:0]             cnt_q;
   logic [31:0]             cnt_d;
   logic [31:0]             len_q;
   logic [31:0]             len_d;
   logic [31:0]             ctrl_q;
   logic [31:0]             ctrl_d;
   logic [`DSTC_FLG_W-1:0]  flags_q;
   logic [`DSTC_FLG_W-1:0]  flags_d;
   logic [`DSTC_FLG_W-1:0]  mask_q;
   logic [`DSTC_FLG_W-1:0]  mask_d;
   logic                    wrapup_q;
   logic                    wrapup_d;
   logic                    zlp_q;
   logic                    zlp_d;
   logic                    en_prev_q;
   logic                    susp_prev_q;
   logic                    armed_q;
   logic                    armed_d;
   logic                    pre_q;
   logic                    pre_d;
   logic                    fetch_d;
   logic                    abort_d;
   logic                    ack_q;
   logic [31:0]             rdat_q;
   logic                    irq_q;
   logic                    run_q;
   logic                    abort_q;
   logic                    fetch_q;
   logic                    wrap_out_q;
   logic                    wb_en_q;
   logic                    tail_q;
   logic                    prod_q;
   logic                    cons_q;

   // Bus decode
   wire        bus_req  = wb_cyc & wb_stb & ~ack_q;
   wire        bus_wr   = bus_req & wb_we;
   wire        bus_rd   = bus_req & ~wb_we;
   wire        hit_cnt  = (wb_adr == `DSTC_OFF_COUNT);
   wire        hit_len  = (wb_adr == `DSTC_OFF_LENGTH);
   wire        hit_stat = (wb_adr == `DSTC_OFF_STATUS);
   wire        hit_flg  = (wb_adr == `DSTC_OFF_FLAGS);
   wire        hit_msk  = (wb_adr == `DSTC_OFF_MASK);
   wire        wr_cnt   = bus_wr & hit_cnt;
   wire        wr_len   = bus_wr & hit_len;
   wire        wr_stat  = bus_wr & hit_stat;
   wire        wr_msk   = bus_wr & hit_msk;
   wire        rd_flg   = bus_rd & hit_flg;
   wire [31:0] wmask;

   // Byte lane mask from the select lines
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         assign wmask[gi*8 +: 8] = {8{wb_sel[gi]}};
      end
   endgenerate

   // Control fields
   wire go_en     = ctrl_q[`DSTC_B_GO_ENABLE];
   wire go_susp   = ctrl_q[`DSTC_B_GO_PAUSE];
   wire unit_dsc  = ctrl_q[`DSTC_B_UNIT];
   wire p_eop_en  = ctrl_q[`DSTC_B_P_EOP];
   wire p_len_en  = ctrl_q[`DSTC_B_P_LENGTH];
   wire p_last_en = ctrl_q[`DSTC_B_P_LAST];
   wire p_part_en = ctrl_q[`DSTC_B_P_PARTIAL];
   wire enabled;

   // Enabled status trails the run request
   dstc_lag #(
      .N      (`DSTC_EN_LAG)
   ) u_lag (
      .ref_clk(ref_clk),
      .resetn (resetn),
      .go     (go_en),
      .lagged (enabled)
   );

   // Progress arithmetic
   wire        in_act    = (state_q == ST_ACT);
   wire        in_fetch  = (state_q == ST_FETCH);
   wire        in_pause  = (state_q == ST_PAUSE);
   wire        boundary  = in_act & buf_done;
   wire [31:0] cnt_inc   = unit_dsc ? 32'h0000_0001 : {16'h0000, buf_bytes};
   wire [31:0] cnt_sum   = cnt_q + cnt_inc;
   wire        len_set   = (len_q != 32'h0000_0000);
   wire        reached   = len_set & (cnt_sum >= len_q);
   wire [31:0] pre_inc   = unit_dsc ? 32'h0000_0001 : {16'h0000, dsc_size};
   wire [31:0] pre_sum   = cnt_q + pre_inc;
   wire        loaded    = in_fetch & dsc_fetch_done;
   wire        zlp_evt   = boundary & buf_eop & (buf_bytes == 16'h0000);

   // Pause causes
   wire        p_req     = boundary & go_susp;
   wire        p_eop     = boundary & buf_eop & p_eop_en;
   wire        p_len     = boundary & reached & p_len_en;
   wire        p_last    = loaded & p_last_en & len_set & (pre_sum >= len_q);
   wire        p_part    = loaded & p_part_en & (dsc_bytes < dsc_size);
   wire        p_any_act = p_req | p_eop | p_len;
   wire        p_any_pre = p_last | p_part;

   // Flag sets and read-clear
   wire [`DSTC_FLG_W-1:0] flg_set = {p_part, p_last, p_len, p_eop, p_req,
                                     3'h0, zlp_evt, boundary & reached};
   wire [`DSTC_FLG_W-1:0] flg_clr = rd_flg ? {`DSTC_FLG_W{1'b1}} : {`DSTC_FLG_W{1'b0}};

   // Run request edges
   wire en_rise   = go_en & ~en_prev_q;
   wire off_done  = ~go_en & ~enabled & (state_q != ST_OFF);
   wire susp_fall = susp_prev_q & ~go_susp;
   wire causes_clr = (flags_q[`DSTC_FLG_P_PART:`DSTC_FLG_P_REQ] == 5'h00);
   wire resume    = in_pause & armed_q & causes_clr & ~go_susp;

   // State code for the status register
   wire [2:0] st_code = (state_q == ST_FETCH) ? `DSTC_SC_FETCH :
                        (state_q == ST_WAIT)  ? `DSTC_SC_WAIT  :
                        (state_q == ST_ACT)   ? `DSTC_SC_ACT   :
                        (state_q == ST_PAUSE) ? `DSTC_SC_PAUSE : `DSTC_SC_OFF;

   wire [31:0] stat_rd = {ctrl_q[31:29], wrapup_q, ctrl_q[27:21], enabled, in_pause,
                          zlp_q, st_code, 4'h0, ctrl_q[10:0]};

   // Read data selection, unmapped reads return zero
   wire [31:0] rd_data = hit_cnt  ? cnt_q :
                         hit_len  ? len_q :
                         hit_stat ? stat_rd :
                         hit_flg  ? {22'h00_0000, flags_q} :
                         hit_msk  ? {22'h00_0000, mask_q} : 32'h0000_0000;

   // Register next values
   assign cnt_d    = wr_cnt ? ((cnt_q & ~wmask) | (wb_dat_w & wmask)) :
                     boundary ? cnt_sum : cnt_q;
   assign len_d    = wr_len ? ((len_q & ~wmask) | (wb_dat_w & wmask)) : len_q;
   assign ctrl_d   = wr_stat ? ((ctrl_q & ~(wmask & `DSTC_CTRL_RW_MASK)) |
                                (wb_dat_w & wmask & `DSTC_CTRL_RW_MASK)) : ctrl_q;
   assign flags_d  = (flags_q & ~flg_clr) | flg_set;
   assign mask_d   = wr_msk ? ((mask_q & ~wmask[`DSTC_FLG_W-1:0]) |
                               (wb_dat_w[`DSTC_FLG_W-1:0] & wmask[`DSTC_FLG_W-1:0])) : mask_q;
   assign wrapup_d = (wr_stat & wb_sel[3] & wb_dat_w[`DSTC_B_WRAPUP]) |
                     (wrapup_q & ~boundary);
   assign zlp_d    = zlp_evt | (zlp_q & ~(wr_stat & wb_sel[2] & ~wb_dat_w[`DSTC_B_ZLP]));
   assign armed_d  = in_pause ? (armed_q | susp_fall) : 1'b0;

   // Socket sequencing
   always_comb begin
      state_d = state_q;
      fetch_d = 1'b0;
      abort_d = 1'b0;
      pre_d   = pre_q;
      if (en_rise) begin
         state_d = ST_FETCH;
         fetch_d = 1'b1;
      end else if (off_done) begin
         state_d = ST_OFF;
         abort_d = 1'b1;
      end else begin
         unique case (state_q)
            ST_OFF: begin
               state_d = ST_OFF;
            end
            ST_FETCH: begin
               if (dsc_fetch_done) begin
                  if (p_any_pre) begin
                     state_d = ST_PAUSE;
                     pre_d   = 1'b1;
                  end else if (dsc_ready) begin
                     state_d = ST_ACT;
                  end else begin
                     state_d = ST_WAIT;
                  end
               end
            end
            ST_WAIT: begin
               if (dsc_event | dsc_ready) begin
                  state_d = ST_ACT;
               end
            end
            ST_ACT: begin
               if (buf_done) begin
                  if (p_any_act) begin
                     state_d = ST_PAUSE;
                     pre_d   = 1'b0;
                  end else begin
                     state_d = ST_FETCH;
                     fetch_d = 1'b1;
                  end
               end
            end
            ST_PAUSE: begin
               if (resume) begin
                  if (pre_q) begin
                     state_d = dsc_ready ? ST_ACT : ST_WAIT;
                  end else begin
                     state_d = ST_FETCH;
                     fetch_d = 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // State and edge history
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_q     <= ST_OFF;
         en_prev_q   <= 1'b0;
         susp_prev_q <= 1'b0;
         armed_q     <= 1'b0;
         pre_q       <= 1'b0;
      end else begin
         state_q     <= state_d;
         en_prev_q   <= go_en;
         susp_prev_q <= go_susp;
         armed_q     <= armed_d;
         pre_q       <= pre_d;
      end
   end

   // Software visible registers
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q    <= 32'h0000_0000;
         len_q    <= 32'h0000_0000;
         ctrl_q   <= `DSTC_CTRL_RST;
         flags_q  <= `DSTC_FLG_RST;
         mask_q   <= `DSTC_MASK_RST;
         wrapup_q <= 1'b0;
         zlp_q    <= 1'b0;
      end else begin
         cnt_q    <= cnt_d;
         len_q    <= len_d;
         ctrl_q   <= ctrl_d;
         flags_q  <= flags_d;
         mask_q   <= mask_d;
         wrapup_q <= wrapup_d;
         zlp_q    <= zlp_d;
      end
   end

   // Bus answer
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q  <= bus_req;
         rdat_q <= bus_rd ? rd_data : 32'h0000_0000;
      end
   end

   // Interrupt output
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(flags_d & mask_d);
      end
   end

   // Core control outputs
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         run_q      <= 1'b0;
         abort_q    <= 1'b0;
         fetch_q    <= 1'b0;
         wrap_out_q <= 1'b0;
         wb_en_q    <= 1'b0;
         tail_q     <= 1'b0;
         prod_q     <= 1'b0;
         cons_q     <= 1'b0;
      end else begin
         run_q      <= (state_d == ST_ACT);
         abort_q    <= abort_d;
         fetch_q    <= fetch_d;
         wrap_out_q <= wrapup_d & (state_d == ST_ACT);
         wb_en_q    <= ctrl_d[`DSTC_B_GO_ENABLE];
         tail_q     <= ~ctrl_d[`DSTC_B_TRUNCATE];
         prod_q     <= ctrl_d[`DSTC_B_EN_PROD];
         cons_q     <= ctrl_d[`DSTC_B_EN_CONS];
      end
   end

   assign wb_dat_r         = rdat_q;
   assign wb_ack           = ack_q;
   assign irq              = irq_q;
   assign dsc_fetch_req    = fetch_q;
   assign xfer_run         = run_q;
   assign xfer_abort       = abort_q;
   assign xfer_wrapup      = wrap_out_q;
   assign dsc_writeback_en = wb_en_q;
   assign tail_forward     = tail_q;
   assign prod_events_en   = prod_q;
   assign cons_events_en   = cons_q;

endmodule

`default_nettype wire

// ---- tb/dstc_top_sva.sv ----
// Concurrent checks on the ports of the socket transfer control block.
// Assumes binding to dstc_top; one clock, asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module dstc_top_sva (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        resetn,
   // Register bus
   input wire logic        wb_cyc,
   input wire logic        wb_stb,
   input wire logic [31:0] wb_dat_r,
   input wire logic        wb_ack,
   // Socket activity
   input wire logic        dsc_fetch_req,
   input wire logic        xfer_run,
   input wire logic        xfer_abort,
   input wire logic        dsc_writeback_en
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   a_ack_after_take: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
      else $error("bus request not answered in one cycle");
   a_ack_one_cycle: assert property (wb_ack |=> !wb_ack)
      else $error("bus answer held too long");
   a_rdata_idle: assert property (!wb_ack |-> wb_dat_r == 32'h0000_0000)
      else $error("read data outside an answer");
   a_fetch_on_enable: assert property ($rose(dsc_writeback_en) |-> ##[0:2] dsc_fetch_req)
      else $error("no descriptor fetch after enable");
   a_fetch_one_pulse: assert property (dsc_fetch_req |=> !dsc_fetch_req)
      else $error("fetch request longer than one cycle");
   a_abort_after_off: assert property (
      $fell(dsc_writeback_en) && xfer_run |-> ##[1:8] xfer_abort)
      else $error("no abort after disable");
   a_abort_no_wback: assert property (xfer_abort |-> !dsc_writeback_en)
      else $error("write-back allowed during abort");
   a_abort_one_pulse: assert property (xfer_abort |=> !xfer_abort)
      else $error("abort longer than one cycle");
   a_run_when_on: assert property ($rose(xfer_run) |-> dsc_writeback_en)
      else $error("transfer started while disabled");
endmodule

bind dstc_top dstc_top_sva u_dstc_top_sva (.ref_clk, .resetn, .wb_cyc, .wb_stb, .wb_dat_r,
   .wb_ack, .dsc_fetch_req, .xfer_run, .xfer_abort, .dsc_writeback_en);

`default_nettype wire

// ---- tb/dstc_engine_model.sv ----
// Descriptor engine and peripheral core stand-in for the socket control block.
// Assumes the bench sets the knobs just after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module dstc_engine_model (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // Socket side
   input  wire logic        dsc_fetch_req,
   input  wire logic        xfer_run,
   output logic             dsc_fetch_done,
   output logic             dsc_ready,
   output logic      [15:0] dsc_size,
   output logic      [15:0] dsc_bytes,
   output logic             dsc_event,
   output logic             buf_done,
   output logic      [15:0] buf_bytes,
   output logic             buf_eop,
   // Bench knobs
   input  wire logic [3:0]  fetch_lat,
   input  wire logic        have_data,
   input  wire logic [15:0] nbytes,
   input  wire logic        buf_go,
   input  wire logic        eop_lvl
);
   logic [4:0]  wait_q;
   logic        data_q;
   logic        eop_q;
   logic [15:0] nb_q;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wait_q         <= 5'h00;
         data_q         <= 1'b0;
         eop_q          <= 1'b0;
         nb_q           <= 16'h0000;
         dsc_fetch_done <= 1'b0;
         dsc_event      <= 1'b0;
         buf_done       <= 1'b0;
      end else begin
         if (dsc_fetch_req) begin
            wait_q <= {1'b0, fetch_lat} + 5'h01;
         end else if (wait_q != 5'h00) begin
            wait_q <= wait_q - 5'h01;
         end
         dsc_fetch_done <= (wait_q == 5'h01);
         data_q         <= have_data;
         dsc_event      <= have_data & ~data_q;
         buf_done       <= buf_go & xfer_run;
         nb_q           <= nbytes;
         eop_q          <= eop_lvl;
      end
   end

   // Fields are valid only with their strobe; otherwise they show a wrong pattern
   assign dsc_ready = have_data;
   assign dsc_size  = dsc_fetch_done ? 16'h0200 : 16'hFDFF;
   assign dsc_bytes = dsc_fetch_done ? nbytes : ~nbytes;
   assign buf_bytes = buf_done ? nb_q : ~nb_q;
   assign buf_eop   = buf_done ? eop_q : ~eop_q;
endmodule

`default_nettype wire

// ---- tb/dstc_top_bench.sv ----
// Self-checking bench for the socket transfer control block.
// Assumes the engine model stands in for descriptor memory and the core.
`timescale 1ns/1ps
`default_nettype none
`include "dstc_consts.svh"

`define CHK(g, e) begin \
   num_checks++; \
   if ((g) !== (e)) begin \
      num_errors++; \
      $display("wrong value at %0t: got %h expected %h", $time, g, e); \
   end \
end

module dstc_top_bench;
   localparam logic [31:0] RUN = `DSTC_CTRL_RST | 32'h8000_0000;
   localparam logic [31:0] ENB = 32'h0010_0000;
   localparam logic [31:0] PSB = 32'h4000_0000;
   logic        ref_clk, resetn, wb_cyc, wb_stb, wb_we, wb_ack, irq, xfer_wrapup;
   logic        dsc_fetch_req, dsc_fetch_done, dsc_ready, dsc_event, buf_done, buf_eop;
   logic        xfer_run, xfer_abort, dsc_writeback_en, tail_forward;
   logic        prod_events_en, cons_events_en, have_data, buf_go, eop_lvl;
   logic [7:0]  wb_adr;
   logic [3:0]  wb_sel, fetch_lat;
   logic [31:0] wb_dat_w, wb_dat_r, rdat;
   logic [15:0] dsc_size, dsc_bytes, buf_bytes, nbytes;
   int          num_errors, num_checks, cyc_n;

   dstc_top u_dstc_top (.ref_clk, .resetn, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel,
      .wb_dat_w, .wb_dat_r, .wb_ack, .irq, .dsc_fetch_req, .dsc_fetch_done, .dsc_ready,
      .dsc_size, .dsc_bytes, .dsc_event, .buf_done, .buf_bytes, .buf_eop, .xfer_run,
      .xfer_abort, .xfer_wrapup, .dsc_writeback_en, .tail_forward, .prod_events_en,
      .cons_events_en);
   dstc_engine_model u_dstc_engine_model (.ref_clk, .resetn, .dsc_fetch_req, .xfer_run,
      .dsc_fetch_done, .dsc_ready, .dsc_size, .dsc_bytes, .dsc_event, .buf_done,
      .buf_bytes, .buf_eop, .fetch_lat, .have_data, .nbytes, .buf_go, .eop_lvl);

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cyc_n++;
      if (cyc_n == 6000) begin
         num_errors++;
         summarize();
      end
   end

   // One classic cycle, held until the edge that samples ack
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat_w <= d;
      @(posedge ref_clk);
      while (wb_ack !== 1'b1 && n < 40) begin
         n++;
         @(posedge ref_clk);
      end
      rdat = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      `CHK(wb_ack, 1'b1)
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0000_0000);
      `CHK(rdat, e)
   endtask
   task automatic wait_run(input logic v);
      int n;
      n = 0;
      while (xfer_run !== v && n < 40) begin
         n++;
         @(posedge ref_clk);
      end
      `CHK(xfer_run, v)
   endtask
   task automatic bufx(input logic [15:0] b);
      @(posedge ref_clk);
      nbytes <= b;
      buf_go <= 1'b1;
      @(posedge ref_clk);
      buf_go <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask

   initial begin
      {resetn, wb_cyc, wb_stb, wb_we, buf_go, eop_lvl, num_errors, num_checks, cyc_n} = '0;
      {wb_adr, wb_dat_w, fetch_lat, nbytes} = '0;
      wb_sel = 4'hF;
      have_data = 1'b1;
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      rd(`DSTC_OFF_COUNT, 32'h0000_0000);
      rd(`DSTC_OFF_LENGTH, 32'h0000_0000);
      rd(`DSTC_OFF_STATUS, `DSTC_CTRL_RST);
      rd(`DSTC_OFF_FLAGS, 32'h0000_0000);
      rd(`DSTC_OFF_MASK, 32'h0000_0000);
      `CHK(prod_events_en, 1'b1)
      `CHK(cons_events_en, 1'b1)
      wr(8'h08, 32'hFFFF_FFFF);
      rd(8'h08, 32'h0000_0000);
      wr(`DSTC_OFF_LENGTH, 32'hFFFF_FFFF);
      rd(`DSTC_OFF_LENGTH, 32'hFFFF_FFFF);
      wr(`DSTC_OFF_COUNT, 32'hA5A5_5A5A);
      rd(`DSTC_OFF_COUNT, 32'hA5A5_5A5A);
      wr(`DSTC_OFF_COUNT, 32'h0000_0000);
      wr(`DSTC_OFF_LENGTH, 32'h0000_0100);
      wr(`DSTC_OFF_MASK, 32'h0000_0001);
      // Byte mode: length reached pauses the socket
      wr(`DSTC_OFF_STATUS, RUN);
      wait_run(1'b1);
      rd(`DSTC_OFF_STATUS, RUN | ENB | 32'h0001_8000);
      bufx(16'h0080);
      rd(`DSTC_OFF_COUNT, 32'h0000_0080);
      `CHK(irq, 1'b0)
      wait_run(1'b1);
      bufx(16'h0080);
      `CHK(irq, 1'b1)
      `CHK(xfer_run, 1'b0)
      rd(`DSTC_OFF_STATUS, RUN | ENB | 32'h000A_0000);
      rd(`DSTC_OFF_FLAGS, 32'h0000_0081);
      rd(`DSTC_OFF_FLAGS, 32'h0000_0000);
      repeat (2) @(posedge ref_clk);
      `CHK(irq, 1'b0)
      `CHK(xfer_run, 1'b0)
      wr(`DSTC_OFF_COUNT, 32'h0000_0000);
      wr(`DSTC_OFF_STATUS, RUN | PSB);
      wr(`DSTC_OFF_STATUS, RUN);
      wait_run(1'b1);
      wr(`DSTC_OFF_STATUS, RUN | 32'h1000_0000);
      `CHK(xfer_wrapup, 1'b1)
      // Pause by request waits for the buffer to complete, then needs clear causes
      wr(`DSTC_OFF_STATUS, RUN | PSB);
      `CHK(xfer_run, 1'b1)
      bufx(16'h0010);
      wait_run(1'b0);
      `CHK(xfer_wrapup, 1'b0)
      `CHK(irq, 1'b0)
      wr(`DSTC_OFF_STATUS, RUN);
      repeat (4) @(posedge ref_clk);
      `CHK(xfer_run, 1'b0)
      rd(`DSTC_OFF_FLAGS, 32'h0000_0020);
      wait_run(1'b1);
      wr(`DSTC_OFF_STATUS, `DSTC_CTRL_RST);
      wait_run(1'b0);
      repeat (8) @(posedge ref_clk);
      rd(`DSTC_OFF_STATUS, `DSTC_CTRL_RST);
      // Descriptor mode, slow fetch, no data until an event
      have_data <= 1'b0;
      fetch_lat <= 4'h5;
      wr(`DSTC_OFF_COUNT, 32'h0000_0000);
      wr(`DSTC_OFF_LENGTH, 32'h0000_0002);
      wr(`DSTC_OFF_STATUS, (RUN | 32'h2000_0000) & ~32'h00E0_0000);
      repeat (15) @(posedge ref_clk);
      `CHK(xfer_run, 1'b0)
      `CHK(tail_forward, 1'b1)
      `CHK(prod_events_en, 1'b0)
      `CHK(cons_events_en, 1'b0)
      have_data <= 1'b1;
      eop_lvl <= 1'b1;
      wait_run(1'b1);
      bufx(16'h0000);
      eop_lvl <= 1'b0;
      rd(`DSTC_OFF_COUNT, 32'h0000_0001);
      wait_run(1'b1);
      bufx(16'h0040);
      wait_run(1'b0);
      rd(`DSTC_OFF_COUNT, 32'h0000_0002);
      rd(`DSTC_OFF_FLAGS, 32'h0000_0083);
      wr(`DSTC_OFF_STATUS, `DSTC_CTRL_RST);
      repeat (8) @(posedge ref_clk);
      summarize();
   end
endmodule

`default_nettype wire
